// file: core/srs_pkg.sv
// Constants for the set/reset latch source selection block
// Notes on behaviour
// RQ1 - Bit 4: comparator one drives latch set
// RQ2 - Bit 3: reset pin drives latch reset
// RQ3 - Bit 2: pulse clock pulses latch reset
// RQ4 - Bit 1: comparator two drives latch reset
// RQ5 - Bit 0: comparator one drives latch reset
// RQ6 - Bit 5: comparator two drives latch set
// RQ7 - Clocked set enable pulses latch set
// RQ8 - Enabled sources OR into set, reset
`default_nettype none
package srs_pkg;
    // Bus geometry
    localparam int SRS_ADDR_W = 8;
    localparam int SRS_DATA_W = 32;
    // Register byte offsets
    localparam logic [SRS_ADDR_W-1:0] SRS_CTRL_OFS = 8'h00;
    localparam logic [SRS_ADDR_W-1:0] SRS_STAT_OFS = 8'h04;
    // Control field positions
    localparam int SRS_CMP_ONE_RESET_BIT = 0;
    localparam int SRS_CMP_TWO_RESET_BIT = 1;
    localparam int SRS_CLOCKED_RESET_BIT = 2;
    localparam int SRS_PIN_RESET_BIT = 3;
    localparam int SRS_CMP_ONE_SET_BIT = 4;
    localparam int SRS_CMP_TWO_SET_BIT = 5;
    localparam int SRS_CLOCKED_SET_BIT = 6;
    localparam int SRS_CTRL_W = 7;
    localparam logic [SRS_CTRL_W-1:0] SRS_CTRL_RST = 7'h00;
    // Status field positions
    localparam int SRS_ST_CMP_ONE_BIT = 0;
    localparam int SRS_ST_CMP_TWO_BIT = 1;
    localparam int SRS_ST_PIN_BIT = 2;
    localparam int SRS_ST_PCLK_BIT = 3;
    localparam int SRS_ST_SET_BIT = 4;
    localparam int SRS_ST_RESET_BIT = 5;
    localparam int SRS_STAT_W = 6;
    // Synchronised input lanes
    localparam int SRS_IN_W = 4;
    localparam int SRS_IN_CMP_ONE = 0;
    localparam int SRS_IN_CMP_TWO = 1;
    localparam int SRS_IN_PIN = 2;
    localparam int SRS_IN_PCLK = 3;
    localparam logic [SRS_IN_W-1:0] SRS_IN_RST = 4'h0;
    // Synchroniser depth
    localparam int SRS_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// file: core/srs_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
`default_nettype none
module srs_sync
    import srs_pkg::*;
#(
    parameter int WIDTH = SRS_IN_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_lane
            logic meta_ff;
            logic stable_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[gi];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[gi] = stable_ff;
        end
    endgenerate
endmodule
`default_nettype wire

// file: core/srs_source_select.sv
// Set/reset latch source selection with APB control and status
//
// Our own choices: the register addresses and register access over APB.
`default_nettype none
module srs_source_select
    import srs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRS_ADDR_W-1:0] paddr,
    input wire logic [SRS_DATA_W-1:0] pwdata,
    output logic [SRS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous sources
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic latch_reset_pin,
    input wire logic latch_pulse_clock,
    // Drives toward the latch
    output logic latch_set,
    output logic latch_reset
);

    // Every source pin is sampled twice before use, so a level change
    // reaches latch_set or latch_reset on the third pclk edge.
    // Set and reset may both be high; the latch itself resolves that.

    // Address decode, shared by the write and read paths
    function automatic logic addr_is(input logic [SRS_ADDR_W-1:0] a,
                                     input logic [SRS_ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // Software-visible state
    logic [SRS_CTRL_W-1:0] ctrl_ff;
    logic [SRS_DATA_W-1:0] prdata_ff;
    logic [SRS_DATA_W-1:0] nxt_prdata;

    // Latch drive registers and their next values
    logic latch_set_ff;
    logic latch_reset_ff;
    logic nxt_latch_set;
    logic nxt_latch_reset;

    // Source levels before and after the synchroniser
    logic [SRS_IN_W-1:0] raw_in;
    logic [SRS_IN_W-1:0] sync_in;
    logic cmp_one_s;
    logic cmp_two_s;
    logic pin_s;
    logic pulse_clk_s;

    // Pulse clock edge detection
    logic pulse_prev_ff;
    logic pulse_edge;

    // APB phase and address decode terms
    logic setup_phase;
    logic access_phase;
    logic hit_ctrl;
    logic hit_stat;
    logic unmapped;

    // Named views of the control bits
    // Bit 6 carries the clocked set enable above the other six
    logic cmp_one_set_enable;
    logic cmp_two_set_enable;
    logic clocked_set_enable;
    logic pin_reset_enable;
    logic clocked_reset_enable;
    logic cmp_two_reset_enable;
    logic cmp_one_reset_enable;

    assign cmp_one_reset_enable = ctrl_ff[SRS_CMP_ONE_RESET_BIT];
    assign cmp_two_reset_enable = ctrl_ff[SRS_CMP_TWO_RESET_BIT];
    assign clocked_reset_enable = ctrl_ff[SRS_CLOCKED_RESET_BIT];
    assign pin_reset_enable = ctrl_ff[SRS_PIN_RESET_BIT];
    assign cmp_one_set_enable = ctrl_ff[SRS_CMP_ONE_SET_BIT];
    assign cmp_two_set_enable = ctrl_ff[SRS_CMP_TWO_SET_BIT];
    assign clocked_set_enable = ctrl_ff[SRS_CLOCKED_SET_BIT];

    // Pins arrive from outside the clock domain
    // Packed into lanes so one synchroniser bank serves all four
    assign raw_in[SRS_IN_CMP_ONE] = comparator_one;
    assign raw_in[SRS_IN_CMP_TWO] = comparator_two;
    assign raw_in[SRS_IN_PIN] = latch_reset_pin;
    assign raw_in[SRS_IN_PCLK] = latch_pulse_clock;

    srs_sync #(
        .WIDTH(SRS_IN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    // Settled source levels, two pclk edges behind the pins
    assign cmp_one_s = sync_in[SRS_IN_CMP_ONE];
    assign cmp_two_s = sync_in[SRS_IN_CMP_TWO];
    assign pin_s = sync_in[SRS_IN_PIN];
    assign pulse_clk_s = sync_in[SRS_IN_PCLK];

    // Pulse clock edge memory, taken after the synchroniser only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_prev_ff <= 1'b0;
        end else begin
            pulse_prev_ff <= pulse_clk_s;
        end
    end

    // One pclk-wide pulse per rising edge of the latch pulse clock.
    // Limitation: pulse clock must stay well below pclk/4 to be seen.
    // A pulse clock held high yields only the one pulse
    assign pulse_edge = pulse_clk_s & ~pulse_prev_ff;

    // Set sources, each gated by its own enable
    always_comb begin
        nxt_latch_set = 1'b0;
        if (cmp_one_set_enable && cmp_one_s) begin
            nxt_latch_set = 1'b1; // [RQ1] [RQ8]
        end
        if (cmp_two_set_enable && cmp_two_s) begin
            nxt_latch_set = 1'b1; // [RQ6] [RQ8]
        end
        if (clocked_set_enable && pulse_edge) begin
            nxt_latch_set = 1'b1; // [RQ7] [RQ8]
        end
    end

    // Reset sources, each gated by its own enable
    // Not made exclusive with set: both may drive together
    always_comb begin
        nxt_latch_reset = 1'b0;
        if (pin_reset_enable && pin_s) begin
            nxt_latch_reset = 1'b1; // [RQ2] [RQ8]
        end
        if (clocked_reset_enable && pulse_edge) begin
            nxt_latch_reset = 1'b1; // [RQ3] [RQ8]
        end
        if (cmp_two_reset_enable && cmp_two_s) begin
            nxt_latch_reset = 1'b1; // [RQ4] [RQ8]
        end
        if (cmp_one_reset_enable && cmp_one_s) begin
            nxt_latch_reset = 1'b1; // [RQ5] [RQ8]
        end
    end

    // Registered drives keep glitches from the OR trees off the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_set_ff <= 1'b0;
            latch_reset_ff <= 1'b0;
        end else begin
            latch_set_ff <= nxt_latch_set;
            latch_reset_ff <= nxt_latch_reset;
        end
    end

    // Drives leave straight from flops
    assign latch_set = latch_set_ff;
    assign latch_reset = latch_reset_ff;

    // APB phase and decode
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_ctrl = addr_is(paddr, SRS_CTRL_OFS);
    assign hit_stat = addr_is(paddr, SRS_STAT_OFS);
    assign unmapped = ~(hit_ctrl | hit_stat);

    // Zero wait states; unmapped addresses answer with an error
    // Misaligned addresses fall under unmapped as well
    assign pready = 1'b1;
    assign pslverr = access_phase & unmapped;

    // Control register; a status write is silently dropped
    // Bits above the enable field are ignored and read back zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= SRS_CTRL_RST;
        end else if (access_phase && pwrite && hit_ctrl) begin
            ctrl_ff <= pwdata[SRS_CTRL_W-1:0];
        end
    end

    // Read data, captured in setup so it is stable in access
    // Unused upper bits stay zero
    always_comb begin
        nxt_prdata = '0;
        if (hit_ctrl) begin
            nxt_prdata[SRS_CTRL_W-1:0] = ctrl_ff;
        end else if (hit_stat) begin
            nxt_prdata[SRS_ST_CMP_ONE_BIT] = cmp_one_s;
            nxt_prdata[SRS_ST_CMP_TWO_BIT] = cmp_two_s;
            nxt_prdata[SRS_ST_PIN_BIT] = pin_s;
            nxt_prdata[SRS_ST_PCLK_BIT] = pulse_clk_s;
            nxt_prdata[SRS_ST_SET_BIT] = latch_set_ff;
            nxt_prdata[SRS_ST_RESET_BIT] = latch_reset_ff;
        end
    end

    // Status is a snapshot taken at setup; idle bus reads back zero
    // Trade-off: sampling at setup keeps decode off the access path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end else if (!psel) begin
            prdata_ff <= '0;
        end
    end

    // Read data leaves through a flop, never through the decode
    assign prdata = prdata_ff;

endmodule
`default_nettype wire

// file: bench/srs_monitor.sv
// Checker for latch set and reset drives
`default_nettype none
module srs_monitor
    import srs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRS_ADDR_W-1:0] paddr,
    input wire logic [SRS_DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic latch_reset_pin,
    input wire logic latch_pulse_clock,
    input wire logic latch_set,
    input wire logic latch_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] d1_ff, d2_ff, d3_ff, d4_ff;
    logic [6:0] ctl_ff, c_q_ff;
    logic [2:0] up_ff;
    logic ok, pk, es, er;
    // Shadow of the enable field, taken at the APB write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 7'h00;
        end else if (psel && penable && pready && pwrite && paddr == SRS_CTRL_OFS) begin
            ctl_ff <= pwdata[6:0];
        end
    end
    // Delay line: two sync flops plus the output flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c_q_ff, d4_ff, d3_ff, d2_ff, d1_ff} <= 23'h0;
            up_ff <= 3'h0;
        end else begin
            {c_q_ff, d4_ff, d3_ff, d2_ff} <= {ctl_ff, d3_ff, d2_ff, d1_ff};
            d1_ff <= {latch_pulse_clock, latch_reset_pin, comparator_two, comparator_one};
            up_ff <= up_ff + {2'h0, up_ff != 3'h5};
        end
    end
    // Wait until the delay line holds only post-reset samples
    assign ok = up_ff == 3'h5;
    assign pk = d3_ff[3] && !d4_ff[3];
    assign es = c_q_ff[4] & d3_ff[0] | c_q_ff[5] & d3_ff[1] | c_q_ff[6] & pk;
    assign er = c_q_ff[0] & d3_ff[0] | c_q_ff[1] & d3_ff[1] | c_q_ff[3] & d3_ff[2]
        | c_q_ff[2] & pk;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_c1_set: assert property (ok && c_q_ff[4] && d3_ff[0] |-> latch_set)
        else $error("comparator one did not set the latch");
    a_pin_reset: assert property (ok && c_q_ff[3] && d3_ff[2] |-> latch_reset)
        else $error("reset pin did not reset the latch");
    a_clk_reset: assert property (ok && c_q_ff[2] && pk
        |-> latch_reset ##1 latch_reset == er) else $error("pulse clock reset pulse wrong");
    a_c2_reset: assert property (ok && c_q_ff[1] && d3_ff[1] |-> latch_reset)
        else $error("comparator two did not reset the latch");
    a_c1_reset: assert property (ok && c_q_ff[0] && d3_ff[0] |-> latch_reset)
        else $error("comparator one did not reset the latch");
    a_c2_set: assert property (ok && c_q_ff[5] && d3_ff[1] |-> latch_set)
        else $error("comparator two did not set the latch");
    a_clk_set: assert property (ok && c_q_ff[6] && $rose(d3_ff[3])
        |-> latch_set ##1 latch_set == es) else $error("pulse clock set pulse wrong");
    a_set_or: assert property (ok |-> latch_set == es)
        else $error("set drive differs from enabled sources");
    a_reset_or: assert property (ok |-> latch_reset == er)
        else $error("reset drive differs from enabled sources");
endmodule
`default_nettype wire

// file: bench/srs_src_model.sv
// Model of the comparators, reset pin and pulse clock source
`default_nettype none
module srs_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] lvl,
    input wire logic pulse_go,
    output logic comparator_one,
    output logic comparator_two,
    output logic latch_reset_pin,
    output logic latch_pulse_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_ff;
    // Levels follow the bench request directly
    assign {latch_reset_pin, comparator_two, comparator_one} = lvl;
    // Three cycles high, then at least four low: above the two-cycle minimum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= (pulse_go && cnt_ff == 3'h0) ? 3'h6 : cnt_ff - {2'h0, cnt_ff != 3'h0};
        end
    end
    assign latch_pulse_clock = cnt_ff > 3'h3;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Testbench for latch source selection
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    import srs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, latch_set, latch_reset, pulse_go = 1'b0;
    logic comparator_one, comparator_two, latch_reset_pin, latch_pulse_clock;
    logic [2:0] lvl = 3'h0;
    logic [3:0] cs, cr;
    int n_fail = 0, n_compared = 0, cyc = 0;
    // Rows: enables, source levels {pin, c2, c1}, expected {set, reset}
    logic [11:0] rows [10] = '{{7'h10, 3'h1, 2'h2}, {7'h10, 3'h6, 2'h0}, {7'h00, 3'h7, 2'h0},
        {7'h01, 3'h1, 2'h1}, {7'h02, 3'h2, 2'h1}, {7'h08, 3'h4, 2'h1}, {7'h20, 3'h2, 2'h2},
        {7'h33, 3'h3, 2'h3}, {7'h6e, 3'h1, 2'h0}, {7'h08, 3'h3, 2'h0}};
    logic [6:0] pk_ctl [3] = '{7'h40, 7'h04, 7'h00};
    logic [7:0] pk_exp [3] = '{8'h10, 8'h01, 8'h00};
    srs_source_select srs_source_select_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_one(comparator_one),
        .comparator_two(comparator_two), .latch_reset_pin(latch_reset_pin),
        .latch_pulse_clock(latch_pulse_clock), .latch_set(latch_set), .latch_reset(latch_reset));
    srs_src_model srs_src_model_inst (.pclk(pclk), .presetn(presetn), .lvl(lvl),
        .pulse_go(pulse_go), .comparator_one(comparator_one), .comparator_two(comparator_two),
        .latch_reset_pin(latch_reset_pin), .latch_pulse_clock(latch_pulse_clock));
    initial begin
        forever #25 pclk = ~pclk;
    end
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({latch_set, latch_reset}, 2'h0)
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, SRS_CTRL_OFS, {25'h0, rows[i][11:5]});
            lvl <= rows[i][4:2];
            repeat (5) @(posedge pclk);
            `CHK({latch_set, latch_reset}, rows[i][1:0])
        end
        $display("level sources done");
        lvl <= 3'h0;
        // Pulse count over a window: exactly one per pulse-clock rise when enabled, none when not
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, SRS_CTRL_OFS, {25'h0, pk_ctl[i]});
            pulse_go <= 1'b1;
            {cs, cr} = 8'h0;
            @(posedge pclk);
            pulse_go <= 1'b0;
            repeat (12) begin
                @(posedge pclk);
                {cs, cr} = {cs + {3'h0, latch_set}, cr + {3'h0, latch_reset}};
            end
            `CHK({cs, cr}, pk_exp[i])
        end
        $display("pulse sources done");
        apb(1'b1, SRS_CTRL_OFS, 32'hffff_ffff);
        apb(1'b0, SRS_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0000_007f)
        apb(1'b1, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        // Mid-run reset with all three level sources active must clear both drives
        lvl <= 3'h7;
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({latch_set, latch_reset}, 2'h0)
        presetn <= 1'b1;
        apb(1'b1, SRS_STAT_OFS, 32'h0000_007f);
        `CHK(err, 1'b0)
        apb(1'b0, SRS_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0)
        // Status mirrors the settled source levels; nothing enabled drives the latch
        apb(1'b0, SRS_STAT_OFS, 32'h0);
        `CHK(rd, 32'h0000_0007)
        `CHK({latch_set, latch_reset}, 2'h0)
        $display("register and reset done");
        results();
    end
endmodule
bind srs_source_select srs_monitor srs_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .comparator_one(comparator_one), .comparator_two(comparator_two),
    .latch_reset_pin(latch_reset_pin), .latch_pulse_clock(latch_pulse_clock),
    .latch_set(latch_set), .latch_reset(latch_reset));
`default_nettype wire
